// [itrp_pkg.sv]
package itrp_pkg;
  // ****************************************************************
  // port map
  // ****************************************************************
  localparam logic [7:0] PORT_CNT0  = 8'h40;  // counter 0 access port
  localparam logic [7:0] PORT_CNT1  = 8'h41;  // counter 1 access port
  localparam logic [7:0] PORT_CNT2  = 8'h42;  // counter 2 access port
  localparam logic [7:0] PORT_CTRL  = 8'h43;  // control word port
  // ****************************************************************
  // control word fields
  // ****************************************************************
  localparam int CW_SEL_HI    = 7;  // counter select / read back code
  localparam int CW_SEL_LO    = 6;
  localparam int CW_RW_HI     = 5;  // access order
  localparam int CW_RW_LO     = 4;
  localparam int CW_MODE_HI   = 3;  // mode
  localparam int CW_MODE_LO   = 1;
  localparam int CW_BCD       = 0;  // countdown format
  localparam int RB_NOCNT     = 5;  // read back: 0 latches count
  localparam int RB_NOSTAT    = 4;  // read back: 0 latches status
  localparam int RB_SEL_LO    = 1;  // read back counter select base
  localparam logic [1:0] SEL_READBACK = 2'h3;
  // ****************************************************************
  // access order codes
  // ****************************************************************
  localparam logic [1:0] RW_LATCH = 2'h0;
  localparam logic [1:0] RW_LSB   = 2'h1;
  localparam logic [1:0] RW_MSB   = 2'h2;
  localparam logic [1:0] RW_BOTH  = 2'h3;
  // ****************************************************************
  // status byte fields and reset values
  // ****************************************************************
  localparam int ST_OUT   = 7;  // output pin level
  localparam int ST_NULL  = 6;  // count not yet in counting element
  localparam logic [5:0] CFG_RESET = 6'h00;  // access order, mode, bcd
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam int NUM_CNT = 3;
endpackage : itrp_pkg

// [itrp_port.sv]
`timescale 1ns/10ps
`default_nettype none
// one counter's access port: holding register, latches, byte pointers
module itrp_port (
  input  wire  logic        clk_sys,
  input  wire  logic        sys_rst,
  input  wire  logic        wrPort,       // write strobe to this port
  input  wire  logic        rdPort,       // read strobe from this port
  input  wire  logic [7:0]  wrData,
  input  wire  logic        cfgWrite,     // control word for this counter
  input  wire  logic [5:0]  cfgValue,     // access order, mode, bcd
  input  wire  logic        cntLatch,     // count latch request
  input  wire  logic        statLatch,    // status latch request
  input  wire  logic        loadDone,     // holding reg moved to counter
  input  wire  logic        outPin,       // counter output level
  input  wire  logic [15:0] liveCount,    // counting element value
  output logic [7:0]        rdData,       // byte for this read
  output logic [15:0]       countHolding, // count_holding_register
  output logic              countValid,   // pulse: new count written
  output logic [5:0]        cfg           // programmed configuration
);
  // ****************************************************************
  // state
  // ****************************************************************
  logic [15:0] cntHeld;     // latched count
  logic        cntHeldVal;  // latched count awaiting read
  logic [7:0]  statHeld;    // latched status
  logic        statHeldVal; // latched status awaiting read
  logic        nullCount;   // count not yet in counting element
  logic        wrHigh;      // write pointer at high byte
  logic        rdHigh;      // read pointer at high byte
  logic        lastRd;      // read completes the value
  logic [15:0] rdSrc;       // count source for reads
  logic [1:0]  rwMode;      // access order
  logic        wrLast;      // write completes the count
  logic [7:0]  statNow;     // live status byte

  assign rwMode  = cfg[5:4];
  assign rdSrc   = cntHeldVal ? cntHeld : liveCount;
  assign statNow = {outPin, nullCount, cfg};
  assign lastRd  = (rwMode != itrp_pkg::RW_BOTH) || rdHigh;
  assign wrLast  = (rwMode != itrp_pkg::RW_BOTH) || wrHigh;
  // status before count; latched or live count
  always_comb begin
    if (statHeldVal) begin
      rdData = statHeld;
    end else if (rwMode == itrp_pkg::RW_MSB || (rwMode == itrp_pkg::RW_BOTH && rdHigh)) begin
      rdData = rdSrc[15:8];
    end else begin
      rdData = rdSrc[7:0];
    end
  end

  // configuration, pointers and null flag
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cfg          <= itrp_pkg::CFG_RESET;
      wrHigh       <= 1'b0;
      rdHigh       <= 1'b0;
      nullCount    <= 1'b0;
      countHolding <= itrp_pkg::CNT_RESET;
      countValid   <= 1'b0;
    end else begin
      countValid <= wrPort && wrLast;
      if (cfgWrite) begin
        cfg    <= cfgValue;
        wrHigh <= 1'b0;
        rdHigh <= 1'b0;
        nullCount <= 1'b1;
      end else begin
        if (wrPort) begin
          if (rwMode == itrp_pkg::RW_MSB || (rwMode == itrp_pkg::RW_BOTH && wrHigh)) begin
            countHolding[15:8] <= wrData;
          end else begin
            countHolding[7:0] <= wrData;
          end
          if (rwMode == itrp_pkg::RW_BOTH) begin
            wrHigh <= ~wrHigh;
          end
        end
        if (rdPort && !statHeldVal && rwMode == itrp_pkg::RW_BOTH) begin
          rdHigh <= ~rdHigh;
        end
        // null flag set on the write that completes the count, cleared on load
        if (wrPort && wrLast) begin
          nullCount <= 1'b1;
        end else if (loadDone) begin
          nullCount <= 1'b0;
        end
      end
    end
  end

  // latches for count and status
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cntHeld     <= itrp_pkg::CNT_RESET;
      cntHeldVal  <= 1'b0;
      statHeld    <= 8'h00;
      statHeldVal <= 1'b0;
    end else begin
      if (cfgWrite) begin
        cntHeldVal  <= 1'b0;
        statHeldVal <= 1'b0;
      end else begin
        if (cntLatch && !cntHeldVal) begin
          cntHeld    <= liveCount;
          cntHeldVal <= 1'b1;
        end else if (rdPort && !statHeldVal && lastRd) begin
          cntHeldVal <= 1'b0;
        end
        if (statLatch && !statHeldVal) begin
          statHeld    <= statNow;
          statHeldVal <= 1'b1;
        end else if (rdPort) begin
          statHeldVal <= 1'b0;
        end
      end
    end
  end
endmodule : itrp_port
`default_nettype wire

// [itrp_top.sv]
`timescale 1ns/10ps
`default_nettype none
// Operation
// - status latch makes next read status
// - status bit 6 shows unloaded count
// - status bits 5:4 give access order
// - status bits 3:1 give mode
// - status bit 0 gives bcd format
// - ports 40h-42h select counters 0-2
// - byte writes load 16-bit count
// - byte order follows control word
// - reads give live or latched count
// - select 11 is read back command
// - access order 00 latches count
// - repeat latch ignored until read
module itrp_top #(
  parameter int NCNT = itrp_pkg::NUM_CNT  // number of counters
) (
  input  wire  logic             clk_sys,
  input  wire  logic             sys_rst,
  input  wire  logic [7:0]       ioAddr,       // host i/o address
  input  wire  logic             ioWr,         // write strobe, one cycle
  input  wire  logic             ioRd,         // read strobe, one cycle
  input  wire  logic [7:0]       ioWrData,
  input  wire  logic [NCNT-1:0]  outPin,       // counter output pins
  input  wire  logic [NCNT-1:0]  loadDone,     // holding reg moved
  input  wire  logic [16*NCNT-1:0] liveCount,  // counting elements
  output logic [7:0]             ioRdData,     // registered read data
  output logic [16*NCNT-1:0]     countHolding, // count_holding_register
  output logic [NCNT-1:0]        countValid,   // new count pulse
  output logic [6*NCNT-1:0]      cfg           // per-counter config
);
  // ****************************************************************
  // decode
  // ****************************************************************
  logic            ctrlWr;     // control word write
  logic            isRdBack;   // read back command
  logic [NCNT-1:0] portHit;    // counter port decoded
  logic [7:0]      rdByte [NCNT];
  logic [7:0]      next_ioRdData;

  // port address for counter index
  function automatic logic [7:0] portOf(input int idx);
    portOf = itrp_pkg::PORT_CNT0 + 8'(idx);
  endfunction : portOf

  assign ctrlWr   = ioWr && (ioAddr == itrp_pkg::PORT_CTRL);
  assign isRdBack = ioWrData[itrp_pkg::CW_SEL_HI:itrp_pkg::CW_SEL_LO] == itrp_pkg::SEL_READBACK;

  // ****************************************************************
  // counters
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < NCNT; gi++) begin : g_cnt
      logic selNorm;   // control word names this counter
      logic cfgWr;     // mode programming write
      logic cLatch;    // count latch request
      logic sLatch;    // status latch request
      logic rbSel;     // read back selects this counter
      assign portHit[gi] = ioAddr == portOf(gi);
      assign selNorm = !isRdBack && (ioWrData[7:6] == 2'(gi));
      assign rbSel   = isRdBack && ioWrData[itrp_pkg::RB_SEL_LO + gi];
      assign cfgWr   = ctrlWr && selNorm &&
                       (ioWrData[5:4] != itrp_pkg::RW_LATCH);
      assign cLatch  = ctrlWr && ((selNorm && ioWrData[5:4] == itrp_pkg::RW_LATCH) ||
                       (rbSel && !ioWrData[itrp_pkg::RB_NOCNT]));
      assign sLatch  = ctrlWr && rbSel && !ioWrData[itrp_pkg::RB_NOSTAT];
      itrp_port u_port (
        .clk_sys      (clk_sys),
        .sys_rst      (sys_rst),
        .wrPort       (ioWr && portHit[gi]),
        .rdPort       (ioRd && portHit[gi]),
        .wrData       (ioWrData),
        .cfgWrite     (cfgWr),
        .cfgValue     (ioWrData[5:0]),
        .cntLatch     (cLatch),
        .statLatch    (sLatch),
        .loadDone     (loadDone[gi]),
        .outPin       (outPin[gi]),
        .liveCount    (liveCount[16*gi +: 16]),
        .rdData       (rdByte[gi]),
        .countHolding (countHolding[16*gi +: 16]),
        .countValid   (countValid[gi]),
        .cfg          (cfg[6*gi +: 6])
      );
    end
  endgenerate

  // read data mux, zero for unmapped
  always_comb begin
    next_ioRdData = ioRdData;
    if (ioRd) begin
      next_ioRdData = 8'h00;
      for (int i = 0; i < NCNT; i++) begin
        if (portHit[i]) begin
          next_ioRdData = rdByte[i];
        end
      end
    end
  end

  // registered read data
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ioRdData <= 8'h00;
    end else begin
      ioRdData <= next_ioRdData;
    end
  end
endmodule : itrp_top
`default_nettype wire

// [itrp_chk.sv]
`timescale 1ns/10ps
`default_nettype none
// ****
// port checker
// ****
module itrp_chk #(
  parameter int NCNT = 3
) (
  input wire logic               clk_sys,
  input wire logic               sys_rst,
  input wire logic [7:0]         ioAddr,
  input wire logic               ioWr,
  input wire logic               ioRd,
  input wire logic [7:0]         ioWrData,
  input wire logic [NCNT-1:0]    outPin,
  input wire logic [NCNT-1:0]    loadDone,
  input wire logic [16*NCNT-1:0] liveCount,
  input wire logic [7:0]         ioRdData,
  input wire logic [16*NCNT-1:0] countHolding,
  input wire logic [NCNT-1:0]    countValid,
  input wire logic [6*NCNT-1:0]  cfg
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  wire logic cw  = ioWr && ioAddr == 8'h43;  // control word write
  wire logic wr0 = ioWr && ioAddr == 8'h40;  // counter 0 byte write
  // read back latching status of counter 0, then its read
  sequence s_rb0;
    cw && ioWrData[7:6] == 2'h3 && !ioWrData[4] && ioWrData[1];
  endsequence
  sequence s_rd0;
    ioRd && ioAddr == 8'h40;
  endsequence
  a_cfg_write: assert property (cw && ioWrData[7:6] == 2'h0 && ioWrData[5:4] != 2'h0
    |=> cfg[5:0] == $past(ioWrData[5:0])) else $error("config not taken");
  a_latch_keep: assert property (cw && ioWrData[7:6] != 2'h3 && ioWrData[5:4] == 2'h0
    |=> $stable(cfg)) else $error("latch changed config");
  a_lsb_load: assert property (wr0 && cfg[5:4] == 2'h1
    |=> countHolding[7:0] == $past(ioWrData) && countValid[0]) else $error("low byte lost");
  a_msb_load: assert property (wr0 && cfg[5:4] == 2'h2
    |=> countHolding[15:8] == $past(ioWrData) && countValid[0]) else $error("high byte lost");
  a_valid_cause: assert property (countValid[0] |-> $past(wr0))
    else $error("stray count pulse");
  a_unmapped_rd: assert property (ioRd && (ioAddr < 8'h40 || ioAddr > 8'h43)
    |=> ioRdData == 8'h00) else $error("unmapped read not zero");
  a_rdata_hold: assert property (!ioRd |=> $stable(ioRdData))
    else $error("read data moved");
  a_status_cfg: assert property (s_rb0 ##2 s_rd0 |=> ioRdData[5:0] == cfg[5:0])
    else $error("status config wrong");
endmodule : itrp_chk
bind itrp_top itrp_chk #(.NCNT(NCNT)) u_chk (.clk_sys(clk_sys), .sys_rst(sys_rst),
  .ioAddr(ioAddr), .ioWr(ioWr), .ioRd(ioRd), .ioWrData(ioWrData), .outPin(outPin),
  .loadDone(loadDone), .liveCount(liveCount), .ioRdData(ioRdData),
  .countHolding(countHolding), .countValid(countValid), .cfg(cfg));
`default_nettype wire

// [interval_timer_readback_ports_tb.sv]
`timescale 1ns/10ps
`default_nettype none
module interval_timer_readback_ports_tb;
  logic        clk_sys, sys_rst, ioWr, ioRd;  // clock, reset, strobes
  logic [7:0]  ioAddr, ioWrData, ioRdData;
  logic [2:0]  outPin, loadDone, countValid;
  logic [47:0] liveCount, countHolding;
  logic [17:0] cfg;
  int          err_total, cmp_count, i;
  itrp_top i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .ioAddr(ioAddr), .ioWr(ioWr),
    .ioRd(ioRd), .ioWrData(ioWrData), .outPin(outPin), .loadDone(loadDone),
    .liveCount(liveCount), .ioRdData(ioRdData), .countHolding(countHolding),
    .countValid(countValid), .cfg(cfg));
  // 20 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // compare and count
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // one i/o write cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    ioAddr   <= a;
    ioWrData <= d;
    ioWr     <= 1'b1;
    @(posedge clk_sys);
    ioWr <= 1'b0;
  endtask : wr
  // one i/o read cycle, data checked the cycle after
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    ioAddr <= a;
    ioRd   <= 1'b1;
    @(posedge clk_sys);
    ioRd <= 1'b0;
    #1 chk("ioRdData", {8'h00, e}, {8'h00, ioRdData});
  endtask : rd
  task automatic wrap_up();
    if (err_total == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : wrap_up
  // watchdog
  initial begin
    repeat (3000) @(posedge clk_sys);
    err_total++;
    wrap_up();
  end
  // ****
  // tests
  // ****
  initial begin
    sys_rst   = 1'b1;
    ioWr      = 1'b0;
    ioRd      = 1'b0;
    ioAddr    = 8'h00;
    ioWrData  = 8'h00;
    outPin    = 3'b101;
    loadDone  = 3'h0;
    liveCount = {16'h9ABC, 16'h5678, 16'h1234};
    repeat (10) @(posedge clk_sys);
    sys_rst <= 1'b0;
    wr(8'h43, 8'h34);
    wr(8'h40, 8'hAB);
    wr(8'h40, 8'hCD);
    #1 chk("countHolding0", 16'hCDAB, countHolding[15:0]);
    rd(8'h40, 8'h34);
    rd(8'h40, 8'h12);
    wr(8'h43, 8'hE2);
    rd(8'h40, 8'hF4);
    @(posedge clk_sys);
    loadDone <= 3'h1;
    @(posedge clk_sys);
    loadDone <= 3'h0;
    wr(8'h43, 8'hE2);
    rd(8'h40, 8'hB4);
    // pin low must show as status bit 7 low
    outPin <= 3'b100;
    wr(8'h43, 8'hE2);
    rd(8'h40, 8'h34);
    outPin <= 3'b101;
    // access orders 1-3, modes 0-5 and both formats on counter 0
    for (i = 0; i < 6; i++) begin
      wr(8'h43, {2'h0, 2'(i % 3 + 1), 3'(i), i[0]});
      wr(8'h43, 8'hE2);
      rd(8'h40, {2'h3, 2'(i % 3 + 1), 3'(i), i[0]});
      wr(8'h40, 8'(i));
    end
    wr(8'h43, 8'h70);
    rd(8'h41, 8'h78);
    rd(8'h41, 8'h56);
    // counter 2 latch, repeat latch, read back count
    wr(8'h43, 8'hB0);
    wr(8'h43, 8'h80);
    liveCount[47:32] <= 16'h1111;
    wr(8'h43, 8'h80);
    rd(8'h42, 8'hBC);
    rd(8'h42, 8'h9A);
    wr(8'h43, 8'hD8);
    liveCount[47:32] <= 16'h2222;
    rd(8'h42, 8'h11);
    rd(8'h42, 8'h11);
    // latched pair read with another counter in between
    liveCount[47:32] <= 16'h3344;
    wr(8'h43, 8'h80);
    liveCount[47:32] <= 16'h5566;
    rd(8'h42, 8'h44);
    rd(8'h41, 8'h78);
    rd(8'h42, 8'h33);
    rd(8'h50, 8'h00);
    wrap_up();
  end
endmodule : interval_timer_readback_ports_tb
`default_nettype wire
